/* verilog/reset_cause_recorder.sv */
// Reset cause recorder: combines the reset sources into one internal reset,
// records the watchdog and undervoltage causes, and holds the undervoltage
// detector settings, all reachable over a classic Wishbone slave.
// Assumes the watchdog request comes from logic on clk_i and that the pin and
// comparator inputs are asynchronous.
//
// Operation
// RULE1 - Pin reset or power-on clear wipes the whole cause register to zero.
// RULE2 - Reading the cause register returns its contents, then clears it.
// RULE3 - Watchdog reset request sets cause bit 4.
// RULE4 - Undervoltage reset request sets cause bit 0.
// RULE5 - Watchdog or undervoltage reset never clears the other cause flag.
// RULE6 - Pin, power-on and watchdog resets clear undervoltage settings; undervoltage keeps them.
// RULE7 - Cause register is read-only, byte wide, unused bits read zero.
// RULE8 - Power-on clear holds reset until the strap-selected threshold is passed.
// RULE9 - During reset and stabilisation wait, only the program counter is lost.
// RULE10 - A cause event in the same cycle as a read-clear wins over it.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "reset_cause_cfg.svh"

module reset_cause_recorder #(
    parameter int ADDR_W          = 16,
    parameter int OSC_WAIT_CYCLES = `RCR_OSC_WAIT_CYCLES
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output var  logic [31:0]       wb_dat_o,
    output var  logic              wb_ack_o,
    input  wire logic              ext_reset_n_i,
    input  wire logic              vdd_above_low_i,
    input  wire logic              vdd_above_high_i,
    input  wire logic              power_clear_threshold_select_i,
    input  wire logic              undervoltage_detect_i,
    input  wire logic              watchdog_reset_req_i,
    output var  logic              internal_reset_o,
    output var  logic [7:0]        undervoltage_mode_o,
    output var  logic [3:0]        undervoltage_level_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    localparam logic [15:0] OSC_WAIT = 16'(OSC_WAIT_CYCLES);

    logic [4:0]  raw_inputs;
    logic [4:0]  synced;
    logic        pin_reset;
    logic        above_low_s;
    logic        above_high_s;
    logic        thresh_sel_s;
    logic        uv_detect_s;
    logic        poc_hold;
    logic        poc_threshold;
    logic        uv_reset_req;
    logic        any_source;

    logic        wd_flag_ff;
    logic        nxt_wd_flag;
    logic        uv_flag_ff;
    logic        nxt_uv_flag;
    logic [7:0]  uv_mode_ff;
    logic [7:0]  nxt_uv_mode;
    logic [3:0]  uv_level_ff;
    logic [3:0]  nxt_uv_level;
    logic [15:0] osc_cnt_ff;
    logic [15:0] nxt_osc_cnt;
    logic        internal_ff;
    logic        nxt_internal;
    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] dat_ff;
    logic [31:0] nxt_dat;

    logic        take;
    logic        hit_cause;
    logic        hit_mode;
    logic        hit_level;
    logic        hit_status;
    logic        cause_read;
    logic        lane0_write;
    logic [7:0]  cause_byte;
    logic [7:0]  status_byte;

    // ------------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------------
    assign raw_inputs = {undervoltage_detect_i,
                         power_clear_threshold_select_i,
                         vdd_above_high_i,
                         vdd_above_low_i,
                         ext_reset_n_i};

    reset_source_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (raw_inputs),
        .sync_o  (synced)
    );

    assign pin_reset    = ~synced[0];
    assign above_low_s  = synced[1];
    assign above_high_s = synced[2];
    assign thresh_sel_s = synced[3];
    assign uv_detect_s  = synced[4];

    // ------------------------------------------------------------------------
    // Power-on clear
    // ------------------------------------------------------------------------
    power_on_clear_gate u_poc (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .above_low_i        (above_low_s),
        .above_high_i       (above_high_s),
        .threshold_select_i (thresh_sel_s),
        .hold_reset_o       (poc_hold),
        .threshold_o        (poc_threshold)
    );

    // The detector resets the device only when enabled and set to reset mode.
    assign uv_reset_req = uv_detect_s
                        & uv_mode_ff[`RCR_UV_ENABLE_BIT]
                        & uv_mode_ff[`RCR_UV_RESET_SEL_BIT];
    assign any_source   = pin_reset | poc_hold | watchdog_reset_req_i | uv_reset_req;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    assign take        = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign hit_cause   = ({wb_adr_i[ADDR_W-1:2], 2'b00} == `RCR_CAUSE_OFFSET);
    assign hit_mode    = ({wb_adr_i[ADDR_W-1:2], 2'b00} == `RCR_UV_MODE_OFFSET);
    assign hit_level   = ({wb_adr_i[ADDR_W-1:2], 2'b00} == `RCR_UV_LEVEL_OFFSET);
    assign hit_status  = ({wb_adr_i[ADDR_W-1:2], 2'b00} == `RCR_STATUS_OFFSET);
    assign cause_read  = take & ~wb_we_i & hit_cause & wb_sel_i[0];
    assign lane0_write = take & wb_we_i & wb_sel_i[0];

    always_comb begin
        cause_byte                   = `RCR_CAUSE_RESET; // [RULE7]
        cause_byte[`RCR_WD_FLAG_BIT] = wd_flag_ff;
        cause_byte[`RCR_UV_FLAG_BIT] = uv_flag_ff;
        status_byte                       = 8'h00;
        status_byte[`RCR_ST_INTERNAL_BIT] = internal_ff;
        status_byte[`RCR_ST_POC_BIT]      = poc_hold;
        status_byte[`RCR_ST_THRESH_BIT]   = poc_threshold;
        status_byte[`RCR_ST_UV_DETECT_BIT]= uv_detect_s;
        status_byte[`RCR_ST_WD_REQ_BIT]   = watchdog_reset_req_i;
    end

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_ack = take;
        nxt_dat = 32'h0000_0000;
        if (take && !wb_we_i) begin
            if (hit_cause) begin
                nxt_dat = {24'h00_0000, cause_byte}; // [RULE2] [RULE7]
            end else if (hit_mode) begin
                nxt_dat = {24'h00_0000, uv_mode_ff};
            end else if (hit_level) begin
                nxt_dat = {28'h000_0000, uv_level_ff};
            end else if (hit_status) begin
                nxt_dat = {24'h00_0000, status_byte};
            end else begin
                nxt_dat = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
        end
    end

    // ------------------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------------------
    // Writes to the cause register are ignored; only hardware and reads touch it.
    always_comb begin
        nxt_wd_flag = wd_flag_ff;
        nxt_uv_flag = uv_flag_ff;
        if (cause_read) begin
            nxt_wd_flag = 1'b0; // [RULE2]
            nxt_uv_flag = 1'b0; // [RULE2]
        end
        // The watchdog and undervoltage sources each touch only their own flag, after the read-clear.
        if (watchdog_reset_req_i) begin
            nxt_wd_flag = 1'b1; // [RULE3] [RULE5] [RULE10]
        end
        if (uv_reset_req) begin
            nxt_uv_flag = 1'b1; // [RULE4] [RULE5] [RULE10]
        end
        if (pin_reset || poc_hold) begin
            nxt_wd_flag = 1'b0; // [RULE1]
            nxt_uv_flag = 1'b0; // [RULE1]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_flag_ff <= 1'b0;
            uv_flag_ff <= 1'b0;
        end else begin
            wd_flag_ff <= nxt_wd_flag;
            uv_flag_ff <= nxt_uv_flag;
        end
    end

    // ------------------------------------------------------------------------
    // Undervoltage detector settings
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_uv_mode  = uv_mode_ff;
        nxt_uv_level = uv_level_ff;
        if (lane0_write && hit_mode) begin
            nxt_uv_mode = wb_dat_i[7:0] & `RCR_UV_MODE_MASK;
        end
        if (lane0_write && hit_level) begin
            nxt_uv_level = wb_dat_i[3:0];
        end
        if (uv_reset_req) begin
            // Holding the mode also keeps the request alive until recovery.
            nxt_uv_mode  = uv_mode_ff; // [RULE6]
            nxt_uv_level = uv_level_ff; // [RULE6]
        end
        if (pin_reset || poc_hold || watchdog_reset_req_i) begin
            nxt_uv_mode  = `RCR_UV_MODE_RESET; // [RULE6]
            nxt_uv_level = `RCR_UV_LEVEL_RESET; // [RULE6]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uv_mode_ff  <= `RCR_UV_MODE_RESET;
            uv_level_ff <= `RCR_UV_LEVEL_RESET;
        end else begin
            uv_mode_ff  <= nxt_uv_mode;
            uv_level_ff <= nxt_uv_level;
        end
    end

    // ------------------------------------------------------------------------
    // Internal reset and stabilisation wait
    // ------------------------------------------------------------------------
    // No register here is cleared by the internal reset as such; only the
    // source-specific effects above apply, so state survives the wait.
    always_comb begin
        nxt_osc_cnt = osc_cnt_ff;
        if (any_source) begin
            nxt_osc_cnt = OSC_WAIT; // [RULE9]
        end else if (osc_cnt_ff != 16'h0000) begin
            nxt_osc_cnt = osc_cnt_ff - 16'h0001;
        end
        nxt_internal = any_source | (osc_cnt_ff != 16'h0000); // [RULE8] [RULE9]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_cnt_ff  <= 16'h0000;
            internal_ff <= 1'b1;
        end else begin
            osc_cnt_ff  <= nxt_osc_cnt;
            internal_ff <= nxt_internal;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign wb_ack_o             = ack_ff;
    assign wb_dat_o             = dat_ff;
    assign internal_reset_o     = internal_ff;
    assign undervoltage_mode_o  = uv_mode_ff;
    assign undervoltage_level_o = uv_level_ff;

endmodule

`default_nettype wire

/* include/reset_cause_cfg.svh */
// Constants of the reset cause recorder: register offsets, field positions,
// reset values and timing counts.
// Assumes it is included by its bare name from the design and test files.
`ifndef RESET_CAUSE_CFG_SVH
`define RESET_CAUSE_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define RCR_CAUSE_OFFSET      16'hFFAC
`define RCR_UV_MODE_OFFSET    16'hFFB0
`define RCR_UV_LEVEL_OFFSET   16'hFFB4
`define RCR_STATUS_OFFSET     16'hFFB8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RCR_WD_FLAG_BIT       4
`define RCR_UV_FLAG_BIT       0
`define RCR_UV_ENABLE_BIT     7
`define RCR_UV_RESET_SEL_BIT  1
`define RCR_ST_INTERNAL_BIT   0
`define RCR_ST_POC_BIT        1
`define RCR_ST_THRESH_BIT     2
`define RCR_ST_UV_DETECT_BIT  3
`define RCR_ST_WD_REQ_BIT     4

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define RCR_CAUSE_RESET       8'h00
`define RCR_UV_MODE_RESET     8'h00
`define RCR_UV_LEVEL_RESET    4'h0
`define RCR_UV_MODE_MASK      8'h82

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RCR_OSC_WAIT_CYCLES   16

`endif

/* include/reset_cause_pkg.sv */
// Types used by the power-on-clear gate of the reset cause recorder.
// Assumes the constants header sits in the include path.
package reset_cause_pkg;

    // ------------------------------------------------------------------------
    // Power-on-clear gate states
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        POC_HOLD = 1'b0,
        POC_RUN  = 1'b1
    } poc_state_type;

endpackage

/* verilog/reset_source_sync.sv */
// Two-flop synchronisers for the asynchronous reset sources and comparators.
// Assumes every bit of async_i may change at any time relative to clk_i.
`timescale 1ns/100ps
`default_nettype none

module reset_source_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);

    // ------------------------------------------------------------------------
    // One chain per bit
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            logic meta_ff;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_ff      <= 1'b0;
                    sync_o[gi]   <= 1'b0;
                end else begin
                    meta_ff      <= async_i[gi];
                    sync_o[gi]   <= meta_ff;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

/* verilog/power_on_clear_gate.sv */
// Power-on-clear gate: holds reset from power-up until the supply passes the
// release threshold picked by the threshold select strap.
// Assumes the comparator levels arrive already synchronised to clk_i.
`timescale 1ns/100ps
`default_nettype none

module power_on_clear_gate (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic above_low_i,
    input  wire logic above_high_i,
    input  wire logic threshold_select_i,
    output var  logic hold_reset_o,
    output var  logic threshold_o
);

    reset_cause_pkg::poc_state_type state_ff;
    reset_cause_pkg::poc_state_type nxt_state;
    logic                           captured_ff;
    logic                           nxt_captured;
    logic                           threshold_ff;
    logic                           nxt_threshold;
    logic                           release_ok;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_captured  = 1'b1;
        // The strap is followed while holding, so threshold_o keeps the value in force at release.
        nxt_threshold = hold_reset_o ? threshold_select_i : threshold_ff;
        release_ok    = captured_ff && (threshold_select_i ? above_high_i : above_low_i);
        nxt_state     = state_ff;
        case (state_ff)
            reset_cause_pkg::POC_HOLD: begin
                if (release_ok) begin
                    nxt_state = reset_cause_pkg::POC_RUN; // [RULE8]
                end
            end
            reset_cause_pkg::POC_RUN: begin
                // A dip below the low threshold reasserts reset in either mode.
                if (!above_low_i) begin
                    nxt_state = reset_cause_pkg::POC_HOLD;
                end
            end
            default: begin
                nxt_state = reset_cause_pkg::POC_HOLD;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff     <= reset_cause_pkg::POC_HOLD; // [RULE8]
            captured_ff  <= 1'b0;
            threshold_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            captured_ff  <= nxt_captured;
            threshold_ff <= nxt_threshold;
        end
    end

    assign hold_reset_o = (state_ff == reset_cause_pkg::POC_HOLD);
    assign threshold_o  = threshold_ff;

endmodule

`default_nettype wire

/* test/reset_cause_recorder_props.sv */
// Concurrent checks on the reset cause recorder's bus and reset behaviour.
// Assumes it is bound to the recorder and sees only the recorder's ports.
`timescale 1ns/100ps
`default_nettype none
`include "reset_cause_cfg.svh"

module reset_cause_recorder_chk #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]       wb_dat_o,
    input  wire logic              wb_ack_o,
    input  wire logic              ext_reset_n_i,
    input  wire logic              watchdog_reset_req_i,
    input  wire logic              internal_reset_o,
    input  wire logic [7:0]        undervoltage_mode_o,
    input  wire logic [3:0]        undervoltage_level_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_take_cause_rd;
        s_take ##0 (!wb_we_i && wb_adr_i == `RCR_CAUSE_OFFSET);
    endsequence

    AST_ACK_NEXT: assert property (s_take |=> wb_ack_o)
        else $error("no ack after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    AST_CAUSE_ZERO: assert property (s_take_cause_rd |=> (wb_dat_o & 32'hFFFFFFEE) == 32'h0)
        else $error("unused cause bits read nonzero");
    AST_WD_CLEARS: assert property (watchdog_reset_req_i |=>
        undervoltage_mode_o == 8'h00 && undervoltage_level_o == 4'h0)
        else $error("watchdog reset left detector settings");
    AST_WD_RESET: assert property (watchdog_reset_req_i |=> internal_reset_o)
        else $error("watchdog request did not raise internal reset");
    AST_WAIT_AFTER_WD: assert property ($fell(watchdog_reset_req_i) |-> internal_reset_o [*2])
        else $error("no stabilisation wait");
    AST_PIN_CLEARS: assert property ((!ext_reset_n_i) [*3] |=>
        undervoltage_mode_o == 8'h00 && undervoltage_level_o == 4'h0)
        else $error("pin reset left detector settings");
    AST_MODE_CAUSE: assert property ($changed(undervoltage_mode_o) |-> internal_reset_o ||
        (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == `RCR_UV_MODE_OFFSET))
        else $error("mode changed without cause");
endmodule

bind reset_cause_recorder reset_cause_recorder_chk #(
    .ADDR_W(ADDR_W)
) u_reset_cause_recorder_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_reset_n_i(ext_reset_n_i), .watchdog_reset_req_i(watchdog_reset_req_i),
    .internal_reset_o(internal_reset_o), .undervoltage_mode_o(undervoltage_mode_o),
    .undervoltage_level_o(undervoltage_level_o)
);
`default_nettype wire

/* test/reset_far_side.sv */
// Model of the reset sources: reset pin, supply comparators, strap, watchdog.
// Assumes the bench sets the supply level and fault events at clock edges.
`timescale 1ns/100ps
`default_nettype none

module reset_far_side (
    input  wire logic       pin_low_i,
    input  wire logic [1:0] supply_i,
    input  wire logic       strap_i,
    input  wire logic       sag_i,
    input  wire logic       wd_fire_i,
    output var  logic       ext_reset_n_o,
    output var  logic       above_low_o,
    output var  logic       above_high_o,
    output var  logic       strap_o,
    output var  logic       uv_detect_o,
    output var  logic       wd_req_o
);
    // Supply 0 is below both thresholds, 1 between them, 2 above both.
    assign ext_reset_n_o = !pin_low_i;
    assign above_low_o   = supply_i >= 2'd1;
    assign above_high_o  = supply_i >= 2'd2;
    assign strap_o       = strap_i;
    assign uv_detect_o   = sag_i;
    assign wd_req_o      = wd_fire_i;
endmodule
`default_nettype wire

/* test/tb_reset_cause_recorder.sv */
// Self-checking bench for the reset cause recorder with its source model.
// Assumes the checker is bound through its own file.
`timescale 1ns/100ps
`default_nettype none
`include "reset_cause_cfg.svh"

module tb_reset_cause_recorder;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, pin_low, strap, sag, wd_fire;
    logic [15:0] wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat, wb_rdat, d;
    logic [1:0]  supply;
    logic        wb_ack, ext_n, a_lo, a_hi, strap_s, uv_det, wd_req, int_rst;
    logic [7:0]  mode;
    logic [3:0]  level;
    int          bad_count, tests_run;

    reset_cause_recorder #(.OSC_WAIT_CYCLES(2)) u_reset_cause_recorder (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .ext_reset_n_i(ext_n), .vdd_above_low_i(a_lo),
        .vdd_above_high_i(a_hi), .power_clear_threshold_select_i(strap_s),
        .undervoltage_detect_i(uv_det), .watchdog_reset_req_i(wd_req),
        .internal_reset_o(int_rst), .undervoltage_mode_o(mode), .undervoltage_level_o(level));
    reset_far_side u_reset_far_side (
        .pin_low_i(pin_low), .supply_i(supply), .strap_i(strap), .sag_i(sag),
        .wd_fire_i(wd_fire), .ext_reset_n_o(ext_n), .above_low_o(a_lo), .above_high_o(a_hi),
        .strap_o(strap_s), .uv_detect_o(uv_det), .wd_req_o(wd_req));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // A watchdog request can ride along so that it meets the taking edge.
    task automatic bus(input logic we, input logic [15:0] adr, input logic [31:0] wd,
                       input logic fire, output logic [31:0] rd);
        int n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        wd_fire <= fire;
        do begin
            @(posedge clk_i);
            wd_fire <= 1'b0;
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20) chk("bus ack", 32'h1, 32'h0);
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [15:0] adr, output logic [31:0] v);
        bus(1'b0, adr, 32'h0, 1'b0, v);
    endtask

    task automatic wr(input logic [15:0] adr, input logic [31:0] v);
        bus(1'b1, adr, v, 1'b0, d);
    endtask

    task automatic settle;
        int n = 0;
        repeat (6) @(posedge clk_i);
        while (int_rst !== 1'b0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk("internal reset", 32'h0, {31'h0, int_rst});
    endtask

    task automatic bark;
        wd_fire <= 1'b1;
        @(posedge clk_i);
        wd_fire <= 1'b0;
        settle();
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_defaults;
        rd(`RCR_CAUSE_OFFSET, d); chk("cause at power-up", 32'h0, d);
        wr(`RCR_CAUSE_OFFSET, 32'h11);
        rd(`RCR_CAUSE_OFFSET, d); chk("cause read-only", 32'h0, d);
        rd(16'hFF00, d); chk("unmapped read", 32'h0, d);
        wr(`RCR_UV_MODE_OFFSET, 32'hFF); chk("mode write", 32'h82, {24'h0, mode});
        rd(`RCR_UV_MODE_OFFSET, d); chk("mode read", 32'h82, d);
        $display("test defaults done");
    endtask

    task automatic t_watchdog;
        wr(`RCR_UV_MODE_OFFSET, 32'h82);
        wr(`RCR_UV_LEVEL_OFFSET, 32'h9);
        bark();
        chk("mode after watchdog", 32'h0, {24'h0, mode});
        chk("level after watchdog", 32'h0, {28'h0, level});
        rd(`RCR_CAUSE_OFFSET, d); chk("cause watchdog", 32'h10, d);
        rd(`RCR_CAUSE_OFFSET, d); chk("cause read-clear", 32'h0, d);
        $display("test watchdog done");
    endtask

    task automatic t_undervoltage;
        wr(`RCR_UV_MODE_OFFSET, 32'h82);
        wr(`RCR_UV_LEVEL_OFFSET, 32'h3);
        sag <= 1'b1;
        repeat (8) @(posedge clk_i);
        sag <= 1'b0;
        settle();
        chk("mode kept", 32'h82, {24'h0, mode});
        chk("level kept", 32'h3, {28'h0, level});
        rd(`RCR_UV_LEVEL_OFFSET, d); chk("level read", 32'h3, d);
        bark();
        rd(`RCR_CAUSE_OFFSET, d); chk("uv flag kept", 32'h11, d);
        bark();
        wr(`RCR_UV_MODE_OFFSET, 32'h82);
        sag <= 1'b1;
        repeat (8) @(posedge clk_i);
        sag <= 1'b0;
        settle();
        rd(`RCR_CAUSE_OFFSET, d); chk("wd flag kept", 32'h11, d);
        $display("test undervoltage done");
    endtask

    task automatic t_pin_poc;
        wr(`RCR_UV_MODE_OFFSET, 32'h82);
        bark();
        pin_low <= 1'b1;
        repeat (6) @(posedge clk_i);
        pin_low <= 1'b0;
        settle();
        rd(`RCR_CAUSE_OFFSET, d); chk("pin clears cause", 32'h0, d);
        bark();
        supply <= 2'd0;
        repeat (6) @(posedge clk_i);
        supply <= 2'd1;
        settle();
        rd(`RCR_CAUSE_OFFSET, d); chk("poc clears cause", 32'h0, d);
        strap <= 1'b1;
        supply <= 2'd0;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        supply <= 2'd1;
        repeat (40) @(posedge clk_i);
        chk("held below high threshold", 32'h1, {31'h0, int_rst});
        supply <= 2'd2;
        settle();
        bus(1'b0, `RCR_CAUSE_OFFSET, 32'h0, 1'b1, d); chk("race old data", 32'h0, d);
        settle();
        rd(`RCR_CAUSE_OFFSET, d); chk("set wins over clear", 32'h10, d);
        $display("test pin and power-on done");
    endtask

    // ------------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        chk("run time", 32'h0, 32'h1);
        end_sim();
    end

    initial begin
        {wb_cyc, wb_stb, wb_we, pin_low, strap, sag, wd_fire} = 7'h00;
        {wb_adr, wb_sel, wb_wdat, bad_count, tests_run} = '0;
        wb_sel = 4'h1;
        supply = 2'd2;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        t_defaults();
        t_watchdog();
        t_undervoltage();
        t_pin_poc();
        end_sim();
    end
endmodule
`default_nettype wire
